// ==== common/tatr_pkg.sv ====
package tatr_pkg;

  // Register locations on the serial register port
  localparam logic [7:0] ADDR_AGING     = 8'h10;
  localparam logic [7:0] ADDR_TEMP_INT  = 8'h11;
  localparam logic [7:0] ADDR_TEMP_FRAC = 8'h12;

  // Values after reset; zero degrees is all zeros
  localparam logic [7:0] AGING_RESET     = 8'h00;
  localparam logic [7:0] TEMP_INT_RESET  = 8'h00;
  localparam logic [1:0] TEMP_FRAC_RESET = 2'h0;
  localparam logic [7:0] RDATA_RESET     = 8'h00;
  localparam logic [7:0] CAP_RESET       = 8'h00;

  // Field positions
  localparam int TRIM_SIGN_BIT = 7;
  localparam int FRAC_MSB      = 7;
  localparam int FRAC_LSB      = 6;
  localparam logic [5:0] FRAC_PAD = 6'h00;

  // Periodic conversion interval
  localparam longint unsigned CLOCK_HZ     = 40_000_000;
  localparam longint unsigned PERIODIC_S   = 64;
  localparam longint unsigned PERIOD_LONG  = PERIODIC_S * CLOCK_HZ;
  localparam logic [31:0]     PERIOD_CYCLES = 32'(PERIOD_LONG);

  // Capacitance code limits
  localparam logic signed [9:0] CAP_MIN_S = 10'sh000;
  localparam logic signed [9:0] CAP_MAX_S = 10'sh0ff;
  localparam logic [7:0]        CAP_MIN   = 8'h00;
  localparam logic [7:0]        CAP_MAX   = 8'hff;

  // Temperature result: integer byte and two quarter-degree bits
  typedef struct packed {
    logic [7:0] whole;
    logic [1:0] frac;
  } tatr_temp_s;

  // One register access from the serial front end
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } tatr_reg_req_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_REQ  = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_CAP  = 4'b1000
  } tatr_state_e;

  // Computed code plus signed trim, clamped to the array range
  function automatic logic [7:0] tatr_sat(input logic [7:0] base,
                                          input logic [7:0] trim);
    logic signed [9:0] sum;
    sum = signed'({2'h0, base}) + signed'({{2{trim[TRIM_SIGN_BIT]}}, trim});
    if (sum < CAP_MIN_S) begin
      return CAP_MIN;
    end else if (sum > CAP_MAX_S) begin
      return CAP_MAX;
    end else begin
      return sum[7:0];
    end
  endfunction : tatr_sat

endpackage : tatr_pkg

// ==== hdl/tatr_period_timer.sv ====
`timescale 1ns/100ps
module tatr_period_timer
  import tatr_pkg::*;
#(
  parameter logic [31:0] PERIOD = PERIOD_CYCLES
) (
  input  wire logic clock,
  input  wire logic reset_n,
  output logic      tick
);

  logic [31:0] count_reg;

  // Free-running interval counter; wraps on the last cycle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count_reg <= 32'h0;
    end else if (count_reg == PERIOD - 32'h1) begin
      count_reg <= 32'h0;
    end else begin
      count_reg <= count_reg + 32'h1;
    end
  end

  // One-cycle enable at each interval end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tick <= 1'b0;
    end else begin
      tick <= (count_reg == PERIOD - 32'h1);
    end
  end

endmodule : tatr_period_timer

// ==== hdl/tatr_regs.sv ====
`timescale 1ns/100ps
// How it works
// - Aging trim byte is signed two's complement, bit 7 is the sign.
// - Each manual, first or temperature-changed compensation adds signed trim to computed code, drives the array.
// - Trim applied only on manual conversions, the first after reset, and conversions whose temperature changed.
// - Positive trim adds capacitance, negative trim removes it.
// - Temperature is ten-bit two's complement, quarter-degree steps.
// - Integer byte at first location, fraction in bits 7..6 of next.
// - Reset loads zero degrees, then a conversion starts at once.
// - Conversions on power-up, backup serial access, and every 64 s.
// - Temperature bytes refresh at end of manual and periodic conversions.
// - Temperature bytes are read-only; writes leave them unchanged.
// - The device never drives the serial clock line low.
// - Busy flag rises with conversion request, clears on return to idle.
module tatr_regs
  import tatr_pkg::*;
#(
  parameter logic [31:0] PERIOD = PERIOD_CYCLES
) (
  input  wire logic          clock,
  input  wire logic          reset_n,
  input  wire tatr_reg_req_s reg_req,
  output logic [7:0]         reg_rdata,
  input  wire logic          manual_conversion_request,
  input  wire logic          on_backup,
  input  wire logic          serial_access,
  output logic               sensor_start,
  input  wire logic          sensor_done,
  input  wire tatr_temp_s    sensor_result,
  input  wire logic [7:0]    cap_calc_code,
  output logic [7:0]         cap_array_code,
  output logic               cap_load,
  output logic               compensation_busy_flag,
  output logic               scl_oe
);

  tatr_state_e state_reg;
  tatr_state_e state_next;
  logic [7:0]  aging_reg;
  tatr_temp_s  temp_reg;
  tatr_temp_s  sample_reg;
  logic        pend_reg;
  logic        manual_pend_reg;
  logic        manual_now_reg;
  logic        first_reg;
  logic        period_tick;
  logic        take_req;
  logic        temp_changed;
  logic        apply_trim;
  logic        wr_aging;
  logic        wr_temp;

  // Interval source for periodic conversions
  tatr_period_timer #(
    .PERIOD (PERIOD)
  ) u_timer (
    .clock   (clock),
    .reset_n (reset_n),
    .tick    (period_tick)
  );

  // Access decode
  always_comb begin
    wr_aging = 1'b0;
    wr_temp  = 1'b0;
    if (reg_req.wr && reg_req.addr == ADDR_AGING) begin
      wr_aging = 1'b1;
    end else if (reg_req.wr && (reg_req.addr == ADDR_TEMP_INT ||
                                reg_req.addr == ADDR_TEMP_FRAC)) begin
      wr_temp = 1'b1; // Decoded but deliberately has no effect
    end
  end

  // Aging trim storage, whole byte kept as two's complement
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      aging_reg <= AGING_RESET;
    end else if (wr_aging) begin
      aging_reg <= reg_req.wdata;
    end
  end

  // Read path; unmapped addresses answer zero
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reg_rdata <= RDATA_RESET;
    end else if (reg_req.rd) begin
      if (reg_req.addr == ADDR_AGING) begin
        reg_rdata <= aging_reg;
      end else if (reg_req.addr == ADDR_TEMP_INT) begin
        reg_rdata <= temp_reg.whole;
      end else if (reg_req.addr == ADDR_TEMP_FRAC) begin
        reg_rdata <= {temp_reg.frac, FRAC_PAD};
      end else begin
        reg_rdata <= RDATA_RESET;
      end
    end
  end

  // Pending request; an arrival in the accept cycle is kept
  assign take_req = (state_reg == ST_IDLE) && pend_reg;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pend_reg <= 1'b1;
    end else if (period_tick || manual_conversion_request ||
                 (on_backup && serial_access)) begin
      pend_reg <= 1'b1;
    end else if (take_req) begin
      pend_reg <= 1'b0;
    end
  end

  // Manual origin travels with the request so the trim applies
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      manual_pend_reg <= 1'b0;
    end else if (manual_conversion_request) begin
      manual_pend_reg <= 1'b1;
    end else if (take_req) begin
      manual_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      manual_now_reg <= 1'b0;
    end else if (take_req) begin
      manual_now_reg <= manual_pend_reg || manual_conversion_request;
    end
  end

  // Conversion sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (pend_reg) begin
          state_next = ST_REQ;
        end
      end
      ST_REQ: begin
        state_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (sensor_done) begin
          state_next = ST_CAP;
        end
      end
      ST_CAP: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Start strobe to the sensor, one cycle while in the request state
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sensor_start <= 1'b0;
    end else begin
      sensor_start <= take_req;
    end
  end

  // Busy follows the request and drops back at idle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      compensation_busy_flag <= 1'b0;
    end else if (take_req) begin
      compensation_busy_flag <= 1'b1;
    end else if (state_reg == ST_CAP) begin
      compensation_busy_flag <= 1'b0;
    end
  end

  // Capture the sensor word when it reports done
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sample_reg <= '{whole: TEMP_INT_RESET, frac: TEMP_FRAC_RESET};
    end else if (state_reg == ST_WAIT && sensor_done) begin
      sample_reg <= sensor_result;
    end
  end

  // Published temperature; host writes never reach it
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      temp_reg <= '{whole: TEMP_INT_RESET, frac: TEMP_FRAC_RESET};
    end else if (state_reg == ST_CAP) begin
      temp_reg <= sample_reg;
    end
  end

  // First conversion after reset always sets the array
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      first_reg <= 1'b1;
    end else if (state_reg == ST_CAP) begin
      first_reg <= 1'b0;
    end
  end

  // Unchanged periodic results leave the array alone to avoid churn
  assign temp_changed = (sample_reg != temp_reg);
  assign apply_trim   = manual_now_reg || temp_changed || first_reg;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cap_array_code <= CAP_RESET;
    end else if (state_reg == ST_CAP && apply_trim) begin
      cap_array_code <= tatr_sat(cap_calc_code, aging_reg);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cap_load <= 1'b0;
    end else begin
      cap_load <= (state_reg == ST_CAP) && apply_trim;
    end
  end

  // Serial clock is never stretched
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      scl_oe <= 1'b0;
    end else begin
      scl_oe <= 1'b0;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence s_accept;
    (state_reg == ST_IDLE) && pend_reg;
  endsequence

  sequence s_strobe;
    sensor_start ##1 !sensor_start;
  endsequence

  a_trim_write_store: assert property (
    wr_aging |=> aging_reg == $past(reg_req.wdata))
    else $error("aging trim not stored");

  a_cap_sum_value: assert property (
    cap_load |-> cap_array_code ==
      tatr_sat($past(cap_calc_code), $past(aging_reg)))
    else $error("array code is not sum of trim and code");

  a_cap_apply_gate: assert property (
    cap_load |-> $past(apply_trim))
    else $error("array loaded without cause");

  a_trim_direction: assert property (
    cap_load && !$past(aging_reg[TRIM_SIGN_BIT]) |->
      cap_array_code >= $past(cap_calc_code))
    else $error("positive trim removed capacitance");

  a_temp_refresh: assert property (
    (state_reg == ST_CAP) |=> temp_reg == $past(sample_reg))
    else $error("temperature not refreshed");

  a_temp_readonly: assert property (
    wr_temp && state_reg != ST_CAP |=> $stable(temp_reg))
    else $error("write changed temperature");

  a_frac_low_zero: assert property (
    reg_req.rd && reg_req.addr == ADDR_TEMP_FRAC |=>
      reg_rdata[5:0] == FRAC_PAD && reg_rdata[FRAC_MSB:FRAC_LSB] ==
      $past(temp_reg.frac))
    else $error("fraction byte wrong");

  a_busy_span: assert property (
    (state_reg != ST_IDLE) |-> compensation_busy_flag)
    else $error("busy dropped during conversion");

  a_busy_clear: assert property (
    (state_reg == ST_CAP) |=> !compensation_busy_flag)
    else $error("busy not cleared at idle");

  a_start_strobe: assert property (
    s_accept |=> s_strobe)
    else $error("start strobe missing");

  a_reset_start: assert property (
    $rose(reset_n) |-> temp_reg == '0 ##1 sensor_start)
    else $error("no conversion after reset");

  a_scl_released: assert property (
    !scl_oe)
    else $error("serial clock driven");

endmodule : tatr_regs

// ==== tb/tatr_sensor_model.sv ====
`timescale 1ns/100ps
module tatr_sensor_model
  import tatr_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sensor_start,
  input  wire logic [7:0] delay,
  input  wire tatr_temp_s temp,
  output logic            sensor_done,
  output tatr_temp_s      sensor_result
);
  // Answers each start after delay cycles; result is junk outside done
  initial begin
    sensor_done = 1'b0;
    sensor_result = '0;
    forever begin
      @(posedge clock);
      if (sensor_start === 1'b1) begin
        repeat (delay) @(posedge clock);
        sensor_done <= 1'b1;
        sensor_result <= temp;
        @(posedge clock);
        sensor_done <= 1'b0;
        sensor_result <= ~temp; // Not held once done drops
      end
    end
  end
endmodule : tatr_sensor_model

// ==== tb/tb.sv ====
`timescale 1ns/100ps
module tb
  import tatr_pkg::*;
  ;
  logic          clock;
  logic          reset_n;
  tatr_reg_req_s rq;
  logic [7:0]    rdata, calc, cap, dly;
  logic          man, bak, sacc, start, done, load, busy, scl_oe;
  tatr_temp_s    temp, res;
  int            mismatches, checked, loads, i;
  // Write then read back: addr, wdata, expected
  logic [23:0]   rows [5] = '{24'h107f7f, 24'h108080, 24'h115519,
                              24'h12ff40, 24'h205a00};
  // Trim, computed code, expected array code
  logic [23:0]   trims [4] = '{24'h054045, 24'hfb403b, 24'h7ff0ff,
                               24'h801000};

  tatr_regs #(.PERIOD(32'd200)) uut (
    .clock(clock), .reset_n(reset_n), .reg_req(rq), .reg_rdata(rdata),
    .manual_conversion_request(man), .on_backup(bak),
    .serial_access(sacc), .sensor_start(start), .sensor_done(done),
    .sensor_result(res), .cap_calc_code(calc), .cap_array_code(cap),
    .cap_load(load), .compensation_busy_flag(busy), .scl_oe(scl_oe));

  tatr_sensor_model sensor (.clock(clock), .sensor_start(start),
    .delay(dly), .temp(temp), .sensor_done(done), .sensor_result(res));

  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Counts array loads, sampled where the outputs have settled
  always @(negedge clock) begin
    if (load === 1'b1) loads++;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  // Steps cycles, dropping pulses; clock line must never be pulled
  task automatic cyc(input int n);
    repeat (n) begin
      @(negedge clock);
      rq.wr = 1'b0;
      rq.rd = 1'b0;
      man = 1'b0;
      sacc = 1'b0;
      chk({7'h0, scl_oe}, 8'h00);
    end
  endtask : cyc

  task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(negedge clock);
    rq = '{addr: a, wr: w, rd: !w, wdata: d};
    cyc(1);
  endtask : acc

  // Bounded wait on load (sel 0) or busy (sel 1)
  task automatic wait_on(input int sel, input logic v);
    int n;
    for (n = 0; n < 600 && (sel ? busy : load) !== v; n++) cyc(1);
    if (n == 600) begin
      mismatches++;
      $display("CHECK FAILED at %0t: wait expired", $time);
    end
  endtask : wait_on

  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // Watchdog at 20,000 cycles, well beyond the few hundred cycles the tests need
  initial begin
    #500000;
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    final_report();
  end

  initial begin
    rq = '0; man = 0; bak = 0; sacc = 0; calc = 8'h40; dly = 8'd20;
    temp = '{whole: 8'h19, frac: 2'b01};
    reset_n = 1'b0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    reset_n = 1'b1;
    // Slow sensor so zero degrees is visible before the first result
    acc(ADDR_TEMP_INT, 1'b0, 8'h00);
    chk(rdata, 8'h00);
    chk({7'h0, busy}, 8'h01);
    wait_on(0, 1'b1);
    chk({7'h0, busy}, 8'h00);
    chk(cap, 8'h40);
    $display("test power_up done");
    dly = 8'd1;
    for (i = 0; i < 5; i++) begin
      acc(rows[i][23:16], 1'b1, rows[i][15:8]);
      acc(rows[i][23:16], 1'b0, 8'h00);
      chk(rdata, rows[i][7:0]);
    end
    $display("test registers done");
    temp = '{whole: 8'he7, frac: 2'b11};
    // Manual conversion after each trim change
    for (i = 0; i < 4; i++) begin
      wait_on(1, 1'b0);
      acc(ADDR_AGING, 1'b1, trims[i][23:16]);
      calc = trims[i][15:8];
      @(negedge clock);
      man = 1'b1;
      wait_on(0, 1'b1);
      chk(cap, trims[i][7:0]);
    end
    acc(ADDR_TEMP_INT, 1'b0, 8'h00);
    chk(rdata, 8'he7);
    acc(ADDR_TEMP_FRAC, 1'b0, 8'h00);
    chk(rdata, 8'hc0);
    $display("test trim done");
    // Periodic run with same temperature must not reload the array
    cyc(2);
    loads = 0;
    wait_on(1, 1'b1);
    wait_on(1, 1'b0);
    cyc(2);
    chk(loads[7:0], 8'h00);
    temp = '{whole: 8'h05, frac: 2'b10};
    calc = 8'h90;
    wait_on(0, 1'b1);
    chk(cap, 8'h10);
    acc(ADDR_TEMP_INT, 1'b0, 8'h00);
    chk(rdata, 8'h05);
    $display("test periodic done");
    // Serial access on main supply alone must not convert
    @(negedge clock);
    sacc = 1'b1;
    cyc(2);
    chk({7'h0, busy}, 8'h00);
    // Serial access on backup supply starts a conversion
    loads = 0;
    bak = 1'b1;
    @(negedge clock);
    sacc = 1'b1;
    cyc(2);
    chk({7'h0, busy}, 8'h01);
    wait_on(1, 1'b0);
    cyc(2);
    chk(loads[7:0], 8'h00);
    $display("test backup done");
    // Mid-run reset: trim and temperature return to reset values
    @(negedge clock);
    reset_n = 1'b0;
    cyc(3);
    reset_n = 1'b1;
    acc(ADDR_TEMP_INT, 1'b0, 8'h00);
    chk(rdata, 8'h00);
    chk({7'h0, busy}, 8'h01);
    wait_on(0, 1'b1);
    chk(cap, 8'h90);
    acc(ADDR_AGING, 1'b0, 8'h00);
    chk(rdata, AGING_RESET);
    acc(ADDR_TEMP_INT, 1'b0, 8'h00);
    chk(rdata, 8'h05);
    $display("test reset done");
    final_report();
  end
endmodule : tb
